// ===== logic/rtccs_pkg.sv
package rtccs_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_MODE_CTRL = 5'h01;
  localparam logic [ADDR_W-1:0] OFS_CAL_CTRL = 5'h02;
  // First register fields
  localparam int BIT_OSC_FAULT_IRQ_EN = 7;
  localparam int BIT_TIME_EVENT_IRQ_EN = 6;
  localparam int BIT_ALARM_IRQ_EN = 5;
  localparam int BIT_READ_READY_IRQ_EN = 4;
  localparam int BIT_OSC_FAULT_FLAG = 3;
  localparam int BIT_TIME_EVENT_FLAG = 2;
  localparam int BIT_ALARM_FLAG = 1;
  localparam int BIT_READ_READY_FLAG = 0;
  // Second register fields
  localparam int BIT_DECIMAL_COUNT = 7;
  localparam int BIT_CLOCK_HOLD = 6;
  localparam int BIT_MODE_RSVD_ONE = 5;
  localparam int BIT_VALUES_STABLE = 4;
  localparam int BIT_EVSEL_HI = 1;
  localparam int BIT_EVSEL_LO = 0;
  // Third register fields
  localparam int BIT_TRIM_DIR = 7;
  localparam int BIT_TRIM_MAG_HI = 5;
  localparam int BIT_TRIM_MAG_LO = 0;
  localparam int TRIM_MAG_W = 6;
  // Reset values
  localparam logic [3:0] RST_IRQ_EN = 4'h0;
  localparam logic [3:0] RST_FLAGS = 4'h0;
  localparam logic RST_DECIMAL = 1'b0;
  localparam logic RST_HOLD = 1'b1;
  localparam logic RST_STABLE = 1'b1;
  localparam logic [1:0] RST_EVSEL = 2'h0;
  localparam logic RST_TRIM_DIR = 1'b0;
  localparam logic [TRIM_MAG_W-1:0] RST_TRIM_MAG = 6'h00;
  localparam logic [DATA_W-1:0] RD_UNMAPPED = 8'h00;
  // Time event sources
  typedef enum logic [1:0] {
    RTCCS_EV_MINUTE = 2'h0,
    RTCCS_EV_HOUR = 2'h1,
    RTCCS_EV_MIDNIGHT = 2'h2,
    RTCCS_EV_NOON = 2'h3
  } rtccs_evsel_t;
  // Raw calendar event levels from outside
  typedef struct packed {
    logic minute_changed;
    logic hour_changed;
    logic midnight;
    logic noon;
    logic alarm_match;
    logic osc_fault;
    logic in_transition;
  } rtccs_events_t;
  // Flag and enable grouping: osc, tev, alarm, ready
  typedef struct packed {
    logic osc;
    logic tev;
    logic alarm;
    logic ready;
  } rtccs_quad_t;
endpackage

// ===== logic/rtccs_regs.sv
`timescale 1ns/1ps
module rtccs_regs
  import rtccs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [DATA_W-1:0] rd_data,
  // Calendar event levels, asynchronous
  input wire rtccs_events_t events,
  // Control outputs
  output logic irq,
  output logic wake_req,
  output logic decimal_count_select,
  output logic clock_hold,
  output rtccs_evsel_t time_event_select,
  output logic trim_direction,
  output logic [TRIM_MAG_W-1:0] trim_magnitude
);

  function automatic logic [3:0] quad_bits(input rtccs_quad_t q);
    quad_bits = {q.osc, q.tev, q.alarm, q.ready};
  endfunction

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs, input logic stb);
    reg_hit = stb && (a == ofs);
  endfunction

  rtccs_events_t sync1_reg;
  rtccs_events_t sync2_reg;
  rtccs_events_t prev_reg;
  rtccs_quad_t irq_en_reg;
  rtccs_quad_t flag_reg;
  rtccs_quad_t flag_next;
  rtccs_quad_t flag_set;
  logic decimal_reg;
  logic hold_reg;
  rtccs_evsel_t evsel_reg;
  logic trim_dir_reg;
  logic [TRIM_MAG_W-1:0] trim_mag_reg;
  logic [DATA_W-1:0] rd_data_reg;
  logic [DATA_W-1:0] rd_data_next;
  logic irq_reg;
  logic wake_reg;
  logic wr_irq;
  logic wr_mode;
  logic wr_cal;
  logic values_stable;
  logic tev_pulse;
  logic osc_rise;
  logic alarm_rise;
  logic ready_rise;

  assign wr_irq = reg_hit(addr, OFS_IRQ_CTRL, wr_stb);
  assign wr_mode = reg_hit(addr, OFS_MODE_CTRL, wr_stb);
  assign wr_cal = reg_hit(addr, OFS_CAL_CTRL, wr_stb);

  // Two-stage synchroniser
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= events;
      sync2_reg <= sync1_reg;
    end
  end

  // Edge history
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= sync2_reg;
    end
  end

  assign values_stable = ~sync2_reg.in_transition;
  assign osc_rise = sync2_reg.osc_fault & ~prev_reg.osc_fault;
  assign alarm_rise = sync2_reg.alarm_match & ~prev_reg.alarm_match;
  assign ready_rise = ~sync2_reg.in_transition & prev_reg.in_transition;

  // Selected time event source
  always_comb begin
    unique case (evsel_reg)
      RTCCS_EV_MINUTE: tev_pulse = sync2_reg.minute_changed & ~prev_reg.minute_changed;
      RTCCS_EV_HOUR: tev_pulse = sync2_reg.hour_changed & ~prev_reg.hour_changed;
      RTCCS_EV_MIDNIGHT: tev_pulse = sync2_reg.midnight & ~prev_reg.midnight;
      RTCCS_EV_NOON: tev_pulse = sync2_reg.noon & ~prev_reg.noon;
    endcase
  end

  // Flag next value: hardware set wins over software write
  always_comb begin
    flag_set.osc = osc_rise;
    flag_set.tev = tev_pulse;
    flag_set.alarm = alarm_rise;
    flag_set.ready = ready_rise;
    flag_next = flag_reg;
    if (wr_irq) begin
      flag_next.osc = wr_data[BIT_OSC_FAULT_FLAG];
      flag_next.tev = wr_data[BIT_TIME_EVENT_FLAG];
      flag_next.alarm = wr_data[BIT_ALARM_FLAG];
      flag_next.ready = wr_data[BIT_READ_READY_FLAG];
    end
    flag_next = rtccs_quad_t'(quad_bits(flag_next) | quad_bits(flag_set));
  end

  // Interrupt flags
  always_ff @(posedge clk) begin
    if (rst) begin
      flag_reg <= rtccs_quad_t'(RST_FLAGS);
    end else begin
      flag_reg <= flag_next;
    end
  end

  // Interrupt enables
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_en_reg <= rtccs_quad_t'(RST_IRQ_EN);
    end else if (wr_irq) begin
      irq_en_reg.osc <= wr_data[BIT_OSC_FAULT_IRQ_EN];
      irq_en_reg.tev <= wr_data[BIT_TIME_EVENT_IRQ_EN];
      irq_en_reg.alarm <= wr_data[BIT_ALARM_IRQ_EN];
      irq_en_reg.ready <= wr_data[BIT_READ_READY_IRQ_EN];
    end
  end

  // Mode control
  always_ff @(posedge clk) begin
    if (rst) begin
      decimal_reg <= RST_DECIMAL;
      hold_reg <= RST_HOLD;
      evsel_reg <= rtccs_evsel_t'(RST_EVSEL);
    end else if (wr_mode) begin
      decimal_reg <= wr_data[BIT_DECIMAL_COUNT];
      hold_reg <= wr_data[BIT_CLOCK_HOLD];
      evsel_reg <= rtccs_evsel_t'(wr_data[BIT_EVSEL_HI:BIT_EVSEL_LO]);
    end
  end

  // Calibration control
  always_ff @(posedge clk) begin
    if (rst) begin
      trim_dir_reg <= RST_TRIM_DIR;
      trim_mag_reg <= RST_TRIM_MAG;
    end else if (wr_cal) begin
      trim_dir_reg <= wr_data[BIT_TRIM_DIR];
      trim_mag_reg <= wr_data[BIT_TRIM_MAG_HI:BIT_TRIM_MAG_LO];
    end
  end

  // Read mux
  always_comb begin
    rd_data_next = RD_UNMAPPED;
    if (rd_stb) begin
      unique case (addr)
        OFS_IRQ_CTRL: begin
          rd_data_next[BIT_OSC_FAULT_IRQ_EN] = irq_en_reg.osc;
          rd_data_next[BIT_TIME_EVENT_IRQ_EN] = irq_en_reg.tev;
          rd_data_next[BIT_ALARM_IRQ_EN] = irq_en_reg.alarm;
          rd_data_next[BIT_READ_READY_IRQ_EN] = irq_en_reg.ready;
          rd_data_next[BIT_OSC_FAULT_FLAG] = flag_reg.osc;
          rd_data_next[BIT_TIME_EVENT_FLAG] = flag_reg.tev;
          rd_data_next[BIT_ALARM_FLAG] = flag_reg.alarm;
          rd_data_next[BIT_READ_READY_FLAG] = flag_reg.ready;
        end
        OFS_MODE_CTRL: begin
          rd_data_next[BIT_DECIMAL_COUNT] = decimal_reg;
          rd_data_next[BIT_CLOCK_HOLD] = hold_reg;
          rd_data_next[BIT_MODE_RSVD_ONE] = 1'b1;
          rd_data_next[BIT_VALUES_STABLE] = values_stable;
          rd_data_next[BIT_EVSEL_HI:BIT_EVSEL_LO] = evsel_reg;
        end
        OFS_CAL_CTRL: begin
          rd_data_next[BIT_TRIM_DIR] = trim_dir_reg;
          rd_data_next[BIT_TRIM_MAG_HI:BIT_TRIM_MAG_LO] = trim_mag_reg;
        end
        default: rd_data_next = RD_UNMAPPED;
      endcase
    end
  end

  // Read data, valid one cycle after strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data_reg <= RD_UNMAPPED;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  // Interrupt request and wake request
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      irq_reg <= |(quad_bits(flag_reg) & quad_bits(irq_en_reg));
      wake_reg <= (flag_reg.osc & irq_en_reg.osc) | (flag_reg.tev & irq_en_reg.tev)
                  | (flag_reg.alarm & irq_en_reg.alarm);
    end
  end

  assign rd_data = rd_data_reg;
  assign irq = irq_reg;
  assign wake_req = wake_reg;
  assign decimal_count_select = decimal_reg;
  assign clock_hold = hold_reg;
  assign time_event_select = evsel_reg;
  assign trim_direction = trim_dir_reg;
  assign trim_magnitude = trim_mag_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_irq_follows_flags: assert property (
    ##1 (irq == $past(|(quad_bits(flag_reg) & quad_bits(irq_en_reg)))))
    else $error("irq does not follow flags and enables");
  a_ready_no_wake: assert property (
    (flag_reg.ready && irq_en_reg.ready && !(|(quad_bits(flag_reg) & 4'he & quad_bits(irq_en_reg))))
    |=> !wake_req)
    else $error("ready flag alone raised wake");
  a_osc_flag_sets: assert property (
    osc_rise |=> flag_reg.osc)
    else $error("oscillator fault did not set flag");
  a_alarm_set_wins: assert property (
    (alarm_rise && wr_irq && !wr_data[BIT_ALARM_FLAG]) |=> flag_reg.alarm)
    else $error("alarm set lost against clear");
  a_tev_minute_sel: assert property (
    (evsel_reg == RTCCS_EV_MINUTE && sync2_reg.minute_changed && !prev_reg.minute_changed) |=> flag_reg.tev)
    else $error("minute event did not set flag");
  a_ready_on_stable: assert property (
    $fell(sync2_reg.in_transition) |=> flag_reg.ready)
    else $error("ready flag not set on stable");
  a_mode_rsvd_reads: assert property (
    (rd_stb && addr == OFS_MODE_CTRL) |=> (rd_data[BIT_MODE_RSVD_ONE] && rd_data[3:2] == 2'h0))
    else $error("mode reserved bits read wrong");
  a_cal_rsvd_zero: assert property (
    (rd_stb && addr == OFS_CAL_CTRL) |=> !rd_data[6])
    else $error("calibration reserved bit not zero");
  a_hold_write_takes: assert property (
    wr_mode |=> (clock_hold == $past(wr_data[BIT_CLOCK_HOLD])))
    else $error("hold bit write lost");
  a_trim_write_takes: assert property (
    wr_cal |=> (trim_magnitude == $past(wr_data[5:0]) && trim_direction == $past(wr_data[7])))
    else $error("trim write lost");
  a_unmapped_zero: assert property (
    (rd_stb && addr > OFS_CAL_CTRL) |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_stable_bit_read: assert property (
    (rd_stb && addr == OFS_MODE_CTRL) |=> rd_data[BIT_VALUES_STABLE] == $past(values_stable))
    else $error("stable bit reads wrong");

  // Wake path follows flag and enable pairs
  a_osc_wake_path: assert property (
    (flag_reg.osc && irq_en_reg.osc)
    |=> wake_req)
    else $error("oscillator fault pair did not raise wake");
  a_tev_wake_path: assert property (
    (flag_reg.tev && irq_en_reg.tev)
    |=> wake_req)
    else $error("time event pair did not raise wake");
  a_alarm_wake_path: assert property (
    (flag_reg.alarm && irq_en_reg.alarm)
    |=> wake_req)
    else $error("alarm pair did not raise wake");
  a_wake_needs_pair: assert property (
    !(|(quad_bits(flag_reg) & 4'he & quad_bits(irq_en_reg)))
    |=> !wake_req)
    else $error("wake raised without a wake pair");

  // Enable and flag writes
  a_enable_write_takes: assert property (
    wr_irq
    |=> (quad_bits(irq_en_reg) == $past(wr_data[BIT_OSC_FAULT_IRQ_EN:BIT_READ_READY_IRQ_EN])))
    else $error("enable write lost");
  a_flag_write_sets: assert property (
    wr_irq |=> ((quad_bits(flag_reg) & $past(wr_data[BIT_OSC_FAULT_FLAG:BIT_READ_READY_FLAG]))
      == $past(wr_data[BIT_OSC_FAULT_FLAG:BIT_READ_READY_FLAG])))
    else $error("flag write of one did not set");
  a_flag_write_clears: assert property (
    (wr_irq && !osc_rise && !wr_data[BIT_OSC_FAULT_FLAG])
    |=> !flag_reg.osc)
    else $error("oscillator flag clear lost");
  a_flags_sticky: assert property (
    !wr_irq
    |=> ((quad_bits(flag_reg) & $past(quad_bits(flag_reg))) == $past(quad_bits(flag_reg))))
    else $error("flag dropped without a write");

  // Flag and request paths
  a_alarm_flag_sets: assert property (
    alarm_rise
    |=> flag_reg.alarm)
    else $error("alarm event did not set flag");
  a_irq_needs_pair: assert property (
    !(|(quad_bits(flag_reg) & quad_bits(irq_en_reg)))
    |=> !irq)
    else $error("irq raised without a pair");
  a_ready_pair_irq: assert property (
    (flag_reg.ready && irq_en_reg.ready)
    |=> irq)
    else $error("ready pair did not raise irq");
  a_hold_release: assert property (
    (wr_mode && !wr_data[BIT_CLOCK_HOLD])
    |=> !clock_hold)
    else $error("hold release lost");

  // Time event source selection
  a_tev_hour_sel: assert property (
    (evsel_reg == RTCCS_EV_HOUR && sync2_reg.hour_changed && !prev_reg.hour_changed)
    |=> flag_reg.tev)
    else $error("hour event did not set flag");
  a_tev_midnight_sel: assert property (
    (evsel_reg == RTCCS_EV_MIDNIGHT && sync2_reg.midnight && !prev_reg.midnight)
    |=> flag_reg.tev)
    else $error("midnight event did not set flag");
  a_tev_noon_sel: assert property (
    (evsel_reg == RTCCS_EV_NOON && sync2_reg.noon && !prev_reg.noon)
    |=> flag_reg.tev)
    else $error("noon event did not set flag");
  a_tev_unselected: assert property (
    (evsel_reg == RTCCS_EV_NOON && sync2_reg.minute_changed && !prev_reg.minute_changed
      && !(sync2_reg.noon && !prev_reg.noon) && !flag_reg.tev && !wr_irq)
    |=> !flag_reg.tev)
    else $error("unselected source set time event flag");

  // Mode writes and read images
  a_decimal_write_takes: assert property (
    wr_mode
    |=> (decimal_count_select == $past(wr_data[BIT_DECIMAL_COUNT])))
    else $error("count format write lost");
  a_evsel_write_takes: assert property (
    wr_mode
    |=> (time_event_select == $past(wr_data[BIT_EVSEL_HI:BIT_EVSEL_LO])))
    else $error("event select write lost");
  a_trim_read_image: assert property (
    (rd_stb && addr == OFS_CAL_CTRL) |=> (rd_data[BIT_TRIM_DIR] == $past(trim_dir_reg)
      && rd_data[BIT_TRIM_MAG_HI:BIT_TRIM_MAG_LO] == $past(trim_mag_reg)))
    else $error("calibration read wrong");
  a_irq_read_image: assert property (
    (rd_stb && addr == OFS_IRQ_CTRL)
    |=> (rd_data == $past({quad_bits(irq_en_reg), quad_bits(flag_reg)})))
    else $error("enable and flag read wrong");
  a_mode_read_image: assert property (
    (rd_stb && addr == OFS_MODE_CTRL) |=> (rd_data[BIT_DECIMAL_COUNT] == $past(decimal_reg)
      && rd_data[BIT_CLOCK_HOLD] == $past(hold_reg) && rd_data[BIT_EVSEL_HI:BIT_EVSEL_LO] == $past(evsel_reg)))
    else $error("mode read wrong");
  a_read_idle_zero: assert property (
    !rd_stb
    |=> (rd_data == RD_UNMAPPED))
    else $error("read data not zero when idle");

  // Reset values
  a_reset_clears: assert property (
    $past(rst) |-> (quad_bits(irq_en_reg) == RST_IRQ_EN && quad_bits(flag_reg) == RST_FLAGS
      && trim_direction == RST_TRIM_DIR && trim_magnitude == RST_TRIM_MAG))
    else $error("reset values wrong");
  a_hold_reset_one: assert property (
    $past(rst)
    |-> (clock_hold == RST_HOLD && decimal_count_select == RST_DECIMAL))
    else $error("hold reset value wrong");

  c_irq_raised: cover property ($rose(irq));
  c_wake_raised: cover property ($rose(wake_req));
  c_set_meets_clear: cover property (alarm_rise && wr_irq);
  c_hold_released: cover property ($fell(clock_hold));
  c_tev_flag_set: cover property ($rose(flag_reg.tev));

endmodule

// ===== tb/rtccs_regs_test.sv
`timescale 1ns/1ps
module rtccs_regs_test;
  import rtccs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [ADDR_W-1:0] addr = 5'h00;
  logic [DATA_W-1:0] wr_data = 8'h00;
  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] v;
  rtccs_events_t ev = '0;
  logic irq, wake_req, decimal_count_select, clock_hold, trim_direction;
  rtccs_evsel_t time_event_select;
  logic [TRIM_MAG_W-1:0] trim_magnitude;
  logic [7:0] m0, m1, m2;
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  int seed = 25;

  rtccs_regs rtccs_regs_i (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rd_data(rd_data), .events(ev), .irq(irq), .wake_req(wake_req),
    .decimal_count_select(decimal_count_select), .clock_hold(clock_hold),
    .time_event_select(time_event_select), .trim_direction(trim_direction),
    .trim_magnitude(trim_magnitude));

  always #20 clk = ~clk;

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end

  task automatic close_out();
    $display("Compares %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      fails++;
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    v = rd_data;
  endtask

  // Mode register image: reserved one, live stable bit, zeros in 3-2
  function automatic logic [7:0] exp1(input logic stable);
    return (m1 & 8'hc3) | 8'h20 | {3'h0, stable, 4'h0};
  endfunction

  task automatic outs();
    repeat (2) @(posedge clk);
    #1;
    chk({7'h00, irq}, {7'h00, |(m0[7:4] & m0[3:0])});
    chk({7'h00, wake_req}, {7'h00, |(m0[7:5] & m0[3:1])});
    chk({4'h0, decimal_count_select, clock_hold, time_event_select}, {4'h0, m1[7:6], m1[1:0]});
    chk({trim_direction, 1'b0, trim_magnitude}, m2 & 8'hbf);
  endtask

  task automatic defaults();
    m0 = 8'h00;
    m1 = 8'h40;
    m2 = 8'h00;
    rd(OFS_IRQ_CTRL);
    chk(v, 8'h00);
    rd(OFS_MODE_CTRL);
    chk(v, 8'h70);
    rd(OFS_CAL_CTRL);
    chk(v, 8'h00);
    outs();
  endtask

  task automatic pulse(input int b);
    @(posedge clk);
    ev[b] <= 1'b1;
    repeat (3) @(posedge clk);
    ev[b] <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    defaults();
    $display("Reset values done");
    for (int i = 0; i < 8; i++) begin
      m0 = 8'($random(seed));
      wr(OFS_IRQ_CTRL, m0);
      rd(OFS_IRQ_CTRL);
      chk(v, m0);
      outs();
    end
    $display("Enable and flag writes done");
    for (int i = 0; i < 8; i++) begin
      m1 = 8'($random(seed));
      m2 = 8'($random(seed));
      wr(OFS_MODE_CTRL, m1);
      wr(OFS_CAL_CTRL, m2);
      rd(OFS_MODE_CTRL);
      chk(v, exp1(1'b1));
      rd(OFS_CAL_CTRL);
      chk(v, m2 & 8'hbf);
      outs();
    end
    $display("Mode and trim writes done");
    wr(5'h03, 8'hff);
    wr(5'h1f, 8'hff);
    rd(5'h03);
    chk(v, 8'h00);
    @(posedge clk);
    #1;
    chk(rd_data, 8'h00);
    rd(OFS_IRQ_CTRL);
    chk(v, m0);
    rd(OFS_CAL_CTRL);
    chk(v, m2 & 8'hbf);
    $display("Unmapped access done");
    m0 = 8'hf0;
    wr(OFS_IRQ_CTRL, m0);
    for (int s = 0; s < 4; s++) begin
      m1 = {6'h00, s[1:0]};
      wr(OFS_MODE_CTRL, m1);
      for (int src = 0; src < 4; src++) begin
        pulse(6 - src);
        if (src == s) begin
          m0[2] = 1'b1;
        end
        rd(OFS_IRQ_CTRL);
        chk(v, m0);
        outs();
        m0[2] = 1'b0;
        wr(OFS_IRQ_CTRL, m0);
      end
    end
    pulse(2);
    m0[1] = 1'b1;
    pulse(1);
    m0[3] = 1'b1;
    rd(OFS_IRQ_CTRL);
    chk(v, m0);
    outs();
    @(posedge clk);
    ev[0] <= 1'b1;
    repeat (6) @(posedge clk);
    rd(OFS_MODE_CTRL);
    chk(v, exp1(1'b0));
    @(posedge clk);
    ev[0] <= 1'b0;
    repeat (6) @(posedge clk);
    m0[0] = 1'b1;
    rd(OFS_IRQ_CTRL);
    chk(v, m0);
    rd(OFS_MODE_CTRL);
    chk(v, exp1(1'b1));
    m0 = 8'h1f;
    wr(OFS_IRQ_CTRL, m0);
    outs();
    m0 = 8'h00;
    wr(OFS_IRQ_CTRL, m0);
    outs();
    // Alarm edge meets a clearing write in the same cycle
    @(posedge clk);
    ev[2] <= 1'b1;
    @(posedge clk);
    wr(OFS_IRQ_CTRL, 8'h00);
    ev[2] <= 1'b0;
    m0 = 8'h02;
    rd(OFS_IRQ_CTRL);
    chk(v, m0);
    m0 = 8'h00;
    wr(OFS_IRQ_CTRL, m0);
    rd(OFS_IRQ_CTRL);
    chk(v, m0);
    $display("Event flags done");
    wr(OFS_CAL_CTRL, 8'hbf);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    defaults();
    $display("Second reset done");
    // Configuration rewritten after the lost register contents
    m0 = 8'he0;
    m1 = 8'h81;
    m2 = 8'h85;
    wr(OFS_IRQ_CTRL, m0);
    wr(OFS_MODE_CTRL, m1);
    wr(OFS_CAL_CTRL, m2);
    rd(OFS_IRQ_CTRL);
    chk(v, m0);
    rd(OFS_MODE_CTRL);
    chk(v, exp1(1'b1));
    rd(OFS_CAL_CTRL);
    chk(v, m2 & 8'hbf);
    outs();
    $display("Reconfiguration done");
    close_out();
  end
endmodule
